// file: hdl/pt8_timer.sv
// 8-bit period timer with prescaler, postscaler and AXI4-Lite register slave
//
// Notes on behaviour
// - timer input is the instruction clock, a quarter of the system clock rate
// - prescale select: 00 divide by 1, 01 by 4, 1x by 16
// - each prescaler output pulse adds one to the 8-bit counter
// - counter and period are compared continuously for equality
// - counter counts from zero to period, then returns to zero next increment
// - each counter-period match advances the postscaler by one
// - postscale field code n gives ratio n+1, from 1:1 to 1:16
// - control: postscale bits 6-3, run enable bit 2, prescale bits 1-0
// - each postscaler output sets the period event flag
// - counter and period are readable and writable at any time
// - reset loads counter with 00h and period with FFh
// - timer counts only while run enable is 1
// - prescaler and postscaler clear on counter write, control write, reset
`include "pt8_cfg.svh"

module pt8_timer (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire pt8_pkg::pt8_word_t s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output pt8_pkg::pt8_word_t     s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   irq
);
  import pt8_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `PT8_OFF_COUNT) || (a == `PT8_OFF_PERIOD) ||
                 (a == `PT8_OFF_CONTROL) || (a == `PT8_OFF_FLAG) ||
                 (a == `PT8_OFF_MASK);
  endfunction : addr_known

  function automatic logic [3:0] pre_limit(input logic [1:0] sel);
    case (sel)
      PT8_PRE_1: pre_limit = 4'h0;
      PT8_PRE_4: pre_limit = `PT8_PRE_DIV4;
      default:   pre_limit = `PT8_PRE_DIV16;
    endcase
  endfunction : pre_limit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pt8_bus_state_t wr_state_reg, wr_state_next;
  pt8_bus_state_t rd_state_reg, rd_state_next;
  logic [11:0]    awaddr_reg, awaddr_next;
  logic           aw_have_reg, aw_have_next;
  pt8_word_t      wdata_reg, wdata_next;
  logic [3:0]     wstrb_reg, wstrb_next;
  logic           w_have_reg, w_have_next;
  logic           awready_reg, awready_next;
  logic           wready_reg, wready_next;
  logic           bvalid_reg, bvalid_next;
  logic [1:0]     bresp_reg, bresp_next;
  logic           arready_reg, arready_next;
  logic           rvalid_reg, rvalid_next;
  logic [1:0]     rresp_reg, rresp_next;
  pt8_word_t      rdata_reg, rdata_next;

  logic [7:0]     count_reg, count_next;
  logic [7:0]     period_reg, period_next;
  logic [6:0]     control_reg, control_next;
  logic [1:0]     instr_div_reg, instr_div_next;
  logic [3:0]     pre_cnt_reg, pre_cnt_next;
  logic [3:0]     post_cnt_reg, post_cnt_next;
  logic           flag_reg, flag_next;
  logic           mask_reg, mask_next;
  logic           irq_reg, irq_next;

  logic           do_write;
  logic           wr_lane0;
  logic           instr_tick;
  logic           pre_tick;
  logic           match;
  logic           post_event;

  // ----------------------------------------------------------------
  // bus write channel: address and data taken in either order
  // ----------------------------------------------------------------
  always_comb begin
    wr_state_next = wr_state_reg;
    awaddr_next   = awaddr_reg;
    aw_have_next  = aw_have_reg;
    wdata_next    = wdata_reg;
    wstrb_next    = wstrb_reg;
    w_have_next   = w_have_reg;
    awready_next  = awready_reg;
    wready_next   = wready_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    do_write      = 1'b0;
    case (wr_state_reg)
      PT8_BUS_IDLE: begin
        if (s_axi_awvalid && awready_reg) begin
          awaddr_next  = s_axi_awaddr;
          aw_have_next = 1'b1;
          awready_next = 1'b0;
        end
        if (s_axi_wvalid && wready_reg) begin
          wdata_next  = s_axi_wdata;
          wstrb_next  = s_axi_wstrb;
          w_have_next = 1'b1;
          wready_next = 1'b0;
        end
        if (aw_have_reg && w_have_reg) begin
          do_write      = addr_known(awaddr_reg);
          bresp_next    = addr_known(awaddr_reg) ? `PT8_RESP_OKAY : `PT8_RESP_SLVERR;
          bvalid_next   = 1'b1;
          wr_state_next = PT8_BUS_RESP;
        end
      end
      PT8_BUS_RESP: begin
        if (s_axi_bready) begin
          bvalid_next   = 1'b0;
          aw_have_next  = 1'b0;
          w_have_next   = 1'b0;
          awready_next  = 1'b1;
          wready_next   = 1'b1;
          wr_state_next = PT8_BUS_IDLE;
        end
      end
      default: wr_state_next = PT8_BUS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // bus read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_state_next = rd_state_reg;
    arready_next  = arready_reg;
    rvalid_next   = rvalid_reg;
    rresp_next    = rresp_reg;
    rdata_next    = rdata_reg;
    case (rd_state_reg)
      PT8_BUS_IDLE: begin
        if (s_axi_arvalid && arready_reg) begin
          arready_next  = 1'b0;
          rvalid_next   = 1'b1;
          rresp_next    = addr_known(s_axi_araddr) ? `PT8_RESP_OKAY : `PT8_RESP_SLVERR;
          rd_state_next = PT8_BUS_RESP;
          case (s_axi_araddr)
            `PT8_OFF_COUNT:   rdata_next = {24'h000000, count_reg};
            `PT8_OFF_PERIOD:  rdata_next = {24'h000000, period_reg};
            `PT8_OFF_CONTROL: rdata_next = {25'h0000000, control_reg};
            `PT8_OFF_FLAG:    rdata_next = {30'h00000000, flag_reg, 1'b0};
            `PT8_OFF_MASK:    rdata_next = {30'h00000000, mask_reg, 1'b0};
            default:          rdata_next = 32'h00000000;
          endcase
        end
      end
      PT8_BUS_RESP: begin
        if (s_axi_rready) begin
          rvalid_next   = 1'b0;
          arready_next  = 1'b1;
          rd_state_next = PT8_BUS_IDLE;
        end
      end
      default: rd_state_next = PT8_BUS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // timer core
  // ----------------------------------------------------------------
  assign wr_lane0   = do_write && wstrb_reg[0];
  assign instr_tick = (instr_div_reg == `PT8_INSTR_DIV);
  assign pre_tick   = control_reg[`PT8_RUN_BIT] && instr_tick &&
                      (pre_cnt_reg == pre_limit(control_reg[`PT8_PRE_MSB:`PT8_PRE_LSB]));
  assign match      = (count_reg == period_reg);
  assign post_event = pre_tick && match &&
                      (post_cnt_reg == control_reg[`PT8_POST_MSB:`PT8_POST_LSB]);

  always_comb begin
    count_next     = count_reg;
    period_next    = period_reg;
    control_next   = control_reg;
    instr_div_next = instr_div_reg + 2'h1;
    pre_cnt_next   = pre_cnt_reg;
    post_cnt_next  = post_cnt_reg;
    flag_next      = flag_reg;
    mask_next      = mask_reg;
    // halted timer holds prescaler, counter and postscaler; the instruction divider keeps running
    if (control_reg[`PT8_RUN_BIT] && instr_tick) begin
      pre_cnt_next = pre_tick ? 4'h0 : pre_cnt_reg + 4'h1;
    end
    if (pre_tick) begin
      if (match) begin
        count_next    = 8'h00;
        post_cnt_next = post_event ? 4'h0 : post_cnt_reg + 4'h1;
      end else begin
        count_next = count_reg + 8'h01;
      end
    end
    if (wr_lane0) begin
      case (awaddr_reg)
        `PT8_OFF_COUNT: begin
          count_next    = wdata_reg[7:0];
          pre_cnt_next  = 4'h0;
          post_cnt_next = 4'h0;
        end
        `PT8_OFF_PERIOD:  period_next = wdata_reg[7:0];
        `PT8_OFF_CONTROL: begin
          control_next  = wdata_reg[6:0];
          pre_cnt_next  = 4'h0;
          post_cnt_next = 4'h0;
        end
        `PT8_OFF_MASK: mask_next = wdata_reg[`PT8_FLAG_BIT];
        default: ;
      endcase
    end
    // write-one-to-clear, but a same-cycle event wins
    if (wr_lane0 && (awaddr_reg == `PT8_OFF_FLAG) && wdata_reg[`PT8_FLAG_BIT]) begin
      flag_next = 1'b0;
    end
    if (post_event) begin
      flag_next = 1'b1;
    end
    irq_next = flag_next && mask_next;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg  <= PT8_BUS_IDLE;
      rd_state_reg  <= PT8_BUS_IDLE;
      awaddr_reg    <= 12'h000;
      aw_have_reg   <= 1'b0;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      w_have_reg    <= 1'b0;
      awready_reg   <= 1'b1;
      wready_reg    <= 1'b1;
      bvalid_reg    <= 1'b0;
      bresp_reg     <= `PT8_RESP_OKAY;
      arready_reg   <= 1'b1;
      rvalid_reg    <= 1'b0;
      rresp_reg     <= `PT8_RESP_OKAY;
      rdata_reg     <= 32'h00000000;
      count_reg     <= `PT8_COUNT_RESET;
      period_reg    <= `PT8_PERIOD_RESET;
      control_reg   <= `PT8_CONTROL_RESET;
      instr_div_reg <= 2'h0;
      pre_cnt_reg   <= 4'h0;
      post_cnt_reg  <= 4'h0;
      flag_reg      <= 1'b0;
      mask_reg      <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      wr_state_reg  <= wr_state_next;
      rd_state_reg  <= rd_state_next;
      awaddr_reg    <= awaddr_next;
      aw_have_reg   <= aw_have_next;
      wdata_reg     <= wdata_next;
      wstrb_reg     <= wstrb_next;
      w_have_reg    <= w_have_next;
      awready_reg   <= awready_next;
      wready_reg    <= wready_next;
      bvalid_reg    <= bvalid_next;
      bresp_reg     <= bresp_next;
      arready_reg   <= arready_next;
      rvalid_reg    <= rvalid_next;
      rresp_reg     <= rresp_next;
      rdata_reg     <= rdata_next;
      count_reg     <= count_next;
      period_reg    <= period_next;
      control_reg   <= control_next;
      instr_div_reg <= instr_div_next;
      pre_cnt_reg   <= pre_cnt_next;
      post_cnt_reg  <= post_cnt_next;
      flag_reg      <= flag_next;
      mask_reg      <= mask_next;
      irq_reg       <= irq_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign irq           = irq_reg;
endmodule : pt8_timer

// file: common/pt8_cfg.svh
// register map, field positions, reset values and timing figures of the period timer
`ifndef PT8_CFG_SVH
`define PT8_CFG_SVH

`define PT8_OFF_COUNT      12'h000
`define PT8_OFF_PERIOD     12'h004
`define PT8_OFF_CONTROL    12'h008
`define PT8_OFF_FLAG       12'h00C
`define PT8_OFF_MASK       12'h010

`define PT8_COUNT_RESET    8'h00
`define PT8_PERIOD_RESET   8'hFF
`define PT8_CONTROL_RESET  7'h00

`define PT8_PRE_LSB        0
`define PT8_PRE_MSB        1
`define PT8_RUN_BIT        2
`define PT8_POST_LSB       3
`define PT8_POST_MSB       6
`define PT8_FLAG_BIT       1

`define PT8_PRE_DIV4       4'h3
`define PT8_PRE_DIV16      4'hF
`define PT8_INSTR_DIV      2'h3

`define PT8_RESP_OKAY      2'h0
`define PT8_RESP_SLVERR    2'h2

`endif

// file: common/pt8_pkg.sv
// types shared by the period timer
package pt8_pkg;
  typedef enum logic [1:0] {
    PT8_PRE_1  = 2'h0,
    PT8_PRE_4  = 2'h1,
    PT8_PRE_16 = 2'h2
  } pt8_pre_t;

  typedef enum logic [1:0] {
    PT8_BUS_IDLE = 2'h1,
    PT8_BUS_RESP = 2'h2
  } pt8_bus_state_t;

  typedef logic [31:0] pt8_word_t;
endpackage : pt8_pkg

// file: tb/pt8_timer_asserts.sv
// bus and interrupt assertions for the period timer, bound to its ports
`include "pt8_cfg.svh"
module pt8_timer_asserts (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic [11:0]        s_axi_awaddr,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire pt8_pkg::pt8_word_t s_axi_wdata,
  input wire logic [3:0]         s_axi_wstrb,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic [11:0]        s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire pt8_pkg::pt8_word_t s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               irq
);
  import pt8_pkg::*;
  logic both_take;
  logic rd_take;
  logic rd_mapped;
  assign both_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  // only the five aligned register words answer OKAY
  assign rd_mapped = (s_axi_araddr == `PT8_OFF_COUNT) ||
                     (s_axi_araddr == `PT8_OFF_PERIOD) ||
                     (s_axi_araddr == `PT8_OFF_CONTROL) ||
                     (s_axi_araddr == `PT8_OFF_FLAG) ||
                     (s_axi_araddr == `PT8_OFF_MASK);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  wr_answer_a: assert property (both_take |=>
    !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write response not on time");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response not on time");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  rd_mapped_a: assert property (rd_take && rd_mapped |=>
    s_axi_rresp == `PT8_RESP_OKAY && s_axi_rdata[31:8] == 24'h000000)
    else $error("mapped read wrong response or width");
  rd_unmapped_a: assert property (rd_take && !rd_mapped |=>
    s_axi_rresp == `PT8_RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  wr_unmapped_a: assert property (both_take && s_axi_awaddr > `PT8_OFF_MASK |->
    ##2 s_axi_bresp == `PT8_RESP_SLVERR)
    else $error("unmapped write not refused");
  // a write lands at the edge bvalid rises, and irq drops at that same edge
  irq_clear_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt dropped without a write");
  reset_state_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
    s_axi_awready && !s_axi_bvalid && !s_axi_rvalid && !irq)
    else $error("outputs not in reset state");
  cover property (both_take);
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : pt8_timer_asserts

bind pt8_timer pt8_timer_asserts u_chk (.*);

// file: tb/pt8_tb.sv
// self-checking register-level bench for the period timer
`include "pt8_cfg.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (a), (b)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pt8_pkg::*;
  logic       aclk = 1'b0, aresetn = 1'b0, irq;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  pt8_word_t  s_axi_wdata = 32'h0, s_axi_rdata, got, saved;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic       s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic       s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, got_resp;
  int         err_count = 0, compares = 0, dv, n;
  always #12.5 aclk = ~aclk;
  pt8_timer DUT (.*);
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [11:0] a, input pt8_word_t d, input logic [1:0] e = 2'h0);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (i == 40) begin err_count++; report_and_stop(); end
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, e)
  endtask : wr
  task automatic rd(input logic [11:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (i == 40) begin err_count++; report_and_stop(); end
    s_axi_rready <= 1'b0;
    got = s_axi_rdata;
    got_resp = s_axi_rresp;
  endtask : rd
  task automatic rdc(input logic [11:0] a, input pt8_word_t x);
    rd(a);
    `CHK(got, x)
  endtask : rdc
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(12'h000, 32'h00);
    rdc(12'h004, 32'hFF);
    rdc(12'h008, 32'h00);
    $display("test reset values done");
    wr(12'h004, 32'h5A); rdc(12'h004, 32'h5A);
    wr(12'h000, 32'h33); rdc(12'h000, 32'h33);
    wr(12'h008, 32'hFB); rdc(12'h008, 32'h7B);
    rdc(12'h000, 32'h33);
    s_axi_wstrb <= 4'h0;
    wr(12'h004, 32'h11);
    s_axi_wstrb <= 4'hF;
    rdc(12'h004, 32'h5A);
    rd(12'h020); `CHK(got_resp, 2'h2)
    wr(12'h020, 32'hFF, 2'h2);
    $display("test access done");
    // divider phase is free running, so a count window of one either way is allowed
    for (int c = 0; c < 4; c++) begin
      dv = (c == 0) ? 1 : (c == 1) ? 4 : 16;
      wr(12'h004, 32'hFF);
      wr(12'h000, 32'h00);
      wr(12'h008, 32'h4 | c);
      repeat (40 * dv) @(posedge aclk);
      rd(12'h000); `CHK(got >= 9 && got <= 11, 1'b1)
    end
    wr(12'h008, 32'h00);
    rd(12'h000);
    saved = got;
    repeat (100) @(posedge aclk);
    rdc(12'h000, saved);
    $display("test prescale done");
    wr(12'h010, 32'h2);
    wr(12'h004, 32'h03);
    for (int p = 0; p < 16; p++) begin
      wr(12'h008, 32'h0);
      wr(12'h000, 32'h0);
      wr(12'h00C, 32'h2);
      repeat (2) @(posedge aclk);
      `CHK(irq, 1'b0)
      wr(12'h008, (p << 3) | 4);
      for (n = 0; n < 600 && irq !== 1'b1; n++) @(posedge aclk);
      if (n == 600) begin err_count++; report_and_stop(); end
      `CHK(n >= 16 * p + 8 && n <= 16 * p + 20, 1'b1)
      rd(12'h000); `CHK(got <= 3, 1'b1)
    end
    wr(12'h008, 32'h0);
    wr(12'h010, 32'h0);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0)
    rdc(12'h00C, 32'h2);
    wr(12'h00C, 32'h2); rdc(12'h00C, 32'h0);
    $display("test postscale done");
    // reset again while the timer runs with non-default registers
    wr(12'h004, 32'h21);
    wr(12'h010, 32'h2);
    wr(12'h000, 32'h44);
    wr(12'h008, 32'h05);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(12'h000, 32'h00);
    rdc(12'h004, 32'hFF);
    rdc(12'h008, 32'h00);
    rdc(12'h010, 32'h00);
    rdc(12'h00C, 32'h00);
    `CHK(irq, 1'b0)
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : testbench
